// ===== hw/iobd_top.sv
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "iobd_map.svh"
module iobd_top #(
    parameter int NCARD = 4,
    parameter logic [5:0] CARD_BASE = `IOBD_SC_CARD0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic prio_i,
    output logic irq_o,
    output logic [5:0] irq_loc_o,
    output logic [NCARD-1:0] start_o,
    output logic [NCARD-1:0][15:0] dout_o,
    input wire logic [NCARD-1:0] done_i,
    input wire logic [NCARD-1:0][15:0] din_i,
    output iobd_pkg::iobd_mreq_t mem_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdat_i
);
    import iobd_pkg::*;

    if (NCARD < 1 || NCARD > 8 || int'(CARD_BASE) < 8)
    begin : g_bad
        $error("iobd_top: NCARD or CARD_BASE out of range");
    end

    function automatic logic [NCARD-1:0] card_dec(input logic [5:0] s);
        logic [NCARD-1:0] m;
        m = '0;
        for (int k = 0; k < NCARD; k++)
        begin
            if (s == CARD_BASE + 6'(k))
            begin
                m[k] = 1'h1;
            end
        end
        return m;
    endfunction : card_dec

    ////////////////////////////////////////////////////////////////
    // Bus slave decode
    logic ack_q;
    logic [31:0] dat_q;
    logic go;
    logic wr;
    logic rd;
    logic map_ok;
    logic [2:0] op;
    logic [5:0] sc;
    logic [NCARD-1:0] csel;
    logic setc_w;
    logic clrc_w;
    logic setf_w;
    logic clrf_w;
    logic accout_w;
    logic ftest_bit;
    logic [15:0] inp_word;

    assign op = adr_i[`IOBD_OP_LSB +: 3];
    assign sc = adr_i[`IOBD_SC_LSB +: 6];
    assign map_ok = (adr_i[31:`IOBD_OP_LSB+3] == '0) && (adr_i[1:0] == 2'h0);
    // Unmapped requests still get ack, with zero data and no effect
    assign go = cyc_i && stb_i && !ack_q;
    assign wr = go && we_i && map_ok;
    assign rd = go && !we_i && map_ok;
    assign csel = card_dec(sc);
    assign setc_w = wr && (op == `IOBD_OP_SETC || op == `IOBD_OP_SETCF);
    assign clrf_w = wr && (op == `IOBD_OP_CLRF || op == `IOBD_OP_SETCF); // [R4]
    assign clrc_w = wr && op == `IOBD_OP_CLRC;
    assign setf_w = wr && op == `IOBD_OP_SETF;
    // Partial writes would split a word, so they are ignored
    assign accout_w = wr && op == `IOBD_OP_OUT && sel_i[1:0] == 2'h3;
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    ////////////////////////////////////////////////////////////////
    // Device pin synchronisers
    logic [NCARD-1:0] done_s1_q;
    logic [NCARD-1:0] done_s2_q;
    logic [NCARD-1:0] done_s3_q;
    logic [NCARD-1:0][15:0] din_s1_q;
    logic [NCARD-1:0][15:0] din_s2_q;
    logic [NCARD-1:0] done_e;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            done_s1_q <= '0;
            done_s2_q <= '0;
            done_s3_q <= '0;
        end
        else
        begin
            done_s1_q <= done_i;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        din_s1_q <= din_i;
        din_s2_q <= din_s1_q;
    end

    assign done_e = done_s2_q & ~done_s3_q; // [R6]

    ////////////////////////////////////////////////////////////////
    // Interface cards
    logic [NCARD-1:0] ctl_q;
    logic [NCARD-1:0] flg_q;
    logic [NCARD-1:0] start_q;
    logic [NCARD-1:0][15:0] obuf_q;
    logic [NCARD-1:0][15:0] ibuf_q;
    logic [NCARD-1:0] dma_setc;
    logic [NCARD-1:0] dma_clrc;
    logic [NCARD-1:0] dma_clrf;
    logic [NCARD-1:0] dma_ld;
    logic [NCARD-1:0] set_ctl;
    logic [NCARD-1:0] clr_ctl;
    logic [NCARD-1:0] clr_flg;
    logic [15:0] word_q;

    assign set_ctl = ({NCARD{setc_w}} & csel) | dma_setc;
    assign clr_ctl = ({NCARD{clrc_w}} & csel) | dma_clrc; // [R1]
    assign clr_flg = ({NCARD{clrf_w}} & csel) | dma_clrf; // [R4]

    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < NCARD; i++)
        begin
            if (rst_i)
            begin
                ctl_q[i] <= `IOBD_RST_CTL; // [R2]
                flg_q[i] <= `IOBD_RST_FLG; // [R2]
                start_q[i] <= 1'h0;
            end
            else
            begin
                // Clear wins so end-of-block clear beats the per-word set
                if (clr_ctl[i])
                    ctl_q[i] <= 1'h0; // [R1] [R24]
                else if (set_ctl[i])
                    ctl_q[i] <= 1'h1; // [R4]
                start_q[i] <= set_ctl[i] && !clr_ctl[i]; // [R5]
                // Device done beats a clear in the same cycle
                if (done_e[i])
                    flg_q[i] <= 1'h1; // [R7] [R10]
                else if (clr_flg[i])
                    flg_q[i] <= 1'h0; // [R4]
                else if (setf_w && csel[i])
                    flg_q[i] <= 1'h1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < NCARD; i++)
        begin
            if (rst_i)
            begin
                obuf_q[i] <= '0;
                ibuf_q[i] <= '0;
            end
            else
            begin
                if (dma_ld[i])
                    obuf_q[i] <= word_q;
                else if (accout_w && csel[i])
                    obuf_q[i] <= dat_i[15:0]; // [R3]
                if (done_e[i])
                    ibuf_q[i] <= din_s2_q[i]; // [R9]
            end
        end
    end

    assign start_o = start_q;
    assign dout_o = obuf_q; // [R5]

    ////////////////////////////////////////////////////////////////
    // Block transfer controller
    iobd_asgn_t asgn_q [2];
    logic [1:0] dir_q;
    logic [1:0] sw_q;
    logic [1:0] run_q;
    logic [1:0] cflg_q;
    logic [14:0] mar_q [2];
    logic [15:0] wc_q [2];
    iobd_st_t st_q;
    logic cur_q;
    iobd_mreq_t mem_q;
    logic [1:0] req;
    logic nc;
    logic [NCARD-1:0] own;
    logic [NCARD-1:0] cm;
    logic [15:0] nbuf;
    logic last;
    logic ien_q;

    always_comb
    begin
        own = '0;
        req = '0;
        for (int c = 0; c < 2; c++)
        begin
            // Priority input plays no part here
            req[c] = run_q[c] && !cflg_q[c] && |(card_dec(asgn_q[c].sc) & flg_q); // [R20]
            if (run_q[c] && !cflg_q[c])
                own = own | card_dec(asgn_q[c].sc);
        end
    end

    assign nc = !req[0]; // [R12]
    assign cm = card_dec(asgn_q[cur_q].sc);
    assign last = &wc_q[cur_q]; // [R27]

    always_comb
    begin
        nbuf = '0;
        for (int k = 0; k < NCARD; k++)
        begin
            if (card_dec(asgn_q[nc].sc) == (NCARD'(1) << k))
                nbuf = ibuf_q[k];
        end
    end

    always_comb
    begin
        dma_clrf = '0;
        dma_setc = '0;
        dma_clrc = '0;
        dma_ld = '0;
        if (st_q == ST_POST)
        begin
            dma_clrf = cm; // [R23]
            if (asgn_q[cur_q].setc_opt && !(last && dir_q[cur_q]))
                dma_setc = cm; // [R23]
            if (last && asgn_q[cur_q].clrc_opt)
                dma_clrc = cm; // [R21] [R24]
            if (!dir_q[cur_q])
                dma_ld = cm;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= ST_IDLE;
            cur_q <= 1'h0;
            mem_q <= '0;
            word_q <= '0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    if (|req)
                    begin
                        cur_q <= nc; // [R12]
                        st_q <= ST_XFER; // [R11]
                        mem_q.req <= 1'h1;
                        mem_q.we <= dir_q[nc];
                        mem_q.adr <= mar_q[nc];
                        mem_q.wdat <= nbuf; // [R14]
                    end
                end
                ST_XFER:
                begin
                    if (mem_ack_i)
                    begin
                        mem_q.req <= 1'h0;
                        word_q <= mem_rdat_i; // [R14]
                        st_q <= ST_POST;
                    end
                end
                ST_POST:
                    st_q <= ST_GAP; // [R13]
                ST_GAP:
                    st_q <= ST_IDLE; // [R13]
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    assign mem_o = mem_q;

    always_ff @(posedge clk_i)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (rst_i)
            begin
                asgn_q[c] <= '0;
                dir_q[c] <= 1'h0;
                mar_q[c] <= '0;
                wc_q[c] <= '0;
                sw_q[c] <= 1'h0;
                run_q[c] <= `IOBD_RST_CTL; // [R2]
                cflg_q[c] <= `IOBD_RST_FLG; // [R2]
            end
            else
            begin
                if (st_q == ST_POST && cur_q == 1'(c))
                begin
                    mar_q[c] <= mar_q[c] + 15'h1; // [R27]
                    wc_q[c] <= wc_q[c] + 16'h1; // [R15] [R27]
                end
                if (accout_w && sc == `IOBD_SC_CH1 + 6'(c))
                begin
                    asgn_q[c].setc_opt <= dat_i[`IOBD_AW_SETC]; // [R23]
                    asgn_q[c].clrc_opt <= dat_i[`IOBD_AW_CLRC]; // [R24]
                    asgn_q[c].sc <= dat_i[5:0]; // [R12]
                end
                if (accout_w && sc == `IOBD_SC_CNT1 + 6'(c))
                begin
                    if (sw_q[c])
                        wc_q[c] <= dat_i[15:0]; // [R26]
                    else
                    begin
                        dir_q[c] <= dat_i[`IOBD_MA_DIR]; // [R25]
                        mar_q[c] <= dat_i[14:0]; // [R25]
                    end
                end
                if (sc == `IOBD_SC_CNT1 + 6'(c) && setc_w)
                    sw_q[c] <= 1'h1;
                if (sc == `IOBD_SC_CNT1 + 6'(c) && clrc_w)
                    sw_q[c] <= 1'h0;
                if (sc == `IOBD_SC_CH1 + 6'(c) && setc_w)
                    run_q[c] <= 1'h1;
                if (sc == `IOBD_SC_CH1 + 6'(c) && clrc_w)
                    run_q[c] <= 1'h0; // [R1]
                if (st_q == ST_POST && cur_q == 1'(c) && last)
                    cflg_q[c] <= 1'h1; // [R17] [R21]
                else if (sc == `IOBD_SC_CH1 + 6'(c) && clrf_w)
                    cflg_q[c] <= 1'h0;
                else if (sc == `IOBD_SC_CH1 + 6'(c) && setf_w)
                    cflg_q[c] <= 1'h1; // [R19]
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Interrupt system and read data
    logic pend;
    logic [5:0] ploc;
    logic irq_q;
    logic [5:0] loc_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ien_q <= 1'h0;
        else if (sc == `IOBD_SC_INTSYS && setf_w)
            ien_q <= 1'h1;
        else if (sc == `IOBD_SC_INTSYS && clrf_w)
            ien_q <= 1'h0;
    end

    always_comb
    begin
        pend = 1'h0;
        ploc = '0;
        // Scan high to low so the lowest select code is kept
        for (int k = NCARD - 1; k >= 0; k--)
        begin
            if (ctl_q[k] && flg_q[k] && !own[k])
            begin
                pend = 1'h1; // [R7]
                ploc = CARD_BASE + 6'(k); // [R7]
            end
        end
        for (int c = 1; c >= 0; c--)
        begin
            if (run_q[c] && cflg_q[c])
            begin
                pend = 1'h1; // [R16]
                ploc = `IOBD_SC_CH1 + 6'(c); // [R16]
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_q <= 1'h0;
            loc_q <= '0;
        end
        else
        begin
            irq_q <= pend && ien_q && prio_i; // [R7]
            loc_q <= pend ? ploc : 6'h00;
        end
    end

    assign irq_o = irq_q;
    assign irq_loc_o = loc_q;

    always_comb
    begin
        ftest_bit = |(csel & flg_q); // [R8]
        inp_word = '0;
        for (int k = 0; k < NCARD; k++)
        begin
            if (csel[k])
                inp_word = ibuf_q[k]; // [R9]
        end
        if (sc == `IOBD_SC_INTSYS)
            ftest_bit = ien_q;
        for (int c = 0; c < 2; c++)
        begin
            if (sc == `IOBD_SC_CH1 + 6'(c))
                ftest_bit = cflg_q[c]; // [R17]
            if (sc == `IOBD_SC_CNT1 + 6'(c))
                inp_word = wc_q[c]; // [R18]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'h0;
            dat_q <= '0;
        end
        else
        begin
            ack_q <= go;
            dat_q <= '0;
            if (rd && op == `IOBD_OP_FTEST)
                dat_q[0] <= ftest_bit; // [R8]
            if (rd && op == `IOBD_OP_IN)
                dat_q[15:0] <= inp_word; // [R9] [R18]
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    reset_ready_a: assert property (disable iff (1'b0) $past(rst_i) |-> !(|ctl_q) && (&flg_q)) // [R2]
        else $error("channel not ready after reset");
    clear_ctl_a: assert property (clrc_w && csel[0] && st_q != ST_POST |=> !ctl_q[0]) // [R1]
        else $error("clear-control left control set");
    start_pulse_a: assert property ($rose(ctl_q[0]) |-> start_o[0] ##1 !start_o[0] || ctl_q[0]) // [R5]
        else $error("no start pulse on control set");
    done_flag_a: assert property (done_s2_q[0] && !done_s3_q[0] |=> flg_q[0] ##1 1'b1) // [R7]
        else $error("done did not set flag");
    irq_gate_a: assert property (irq_o |-> $past(ien_q) && $past(prio_i) && $past(pend)) // [R7]
        else $error("interrupt without enable");
    flag_test_a: assert property (rd && op == `IOBD_OP_FTEST && csel[0] && flg_q[0] |=> ack_o && dat_o[0]) // [R8]
        else $error("flag test missed set flag");
    out_buf_a: assert property (accout_w && csel[0] && st_q != ST_POST |=> dout_o[0] == $past(dat_i[15:0])) // [R3]
        else $error("output word not buffered");
    prio_ch1_a: assert property (st_q == ST_IDLE && req[0] && req[1] |=> st_q == ST_XFER && !cur_q) // [R12]
        else $error("channel 2 served before channel 1");
    gap_free_a: assert property (st_q == ST_POST |=> st_q == ST_GAP && !mem_o.req ##1 st_q == ST_IDLE) // [R13]
        else $error("no free memory cycle after steal");
    count_step_a: assert property (st_q == ST_POST && !wr |=> wc_q[cur_q] == $past(wc_q[cur_q]) + 16'h1) // [R27]
        else $error("word count did not step");
    end_flag_a: assert property (st_q == ST_POST && last |=> cflg_q[cur_q] && !(|(req & (2'h1 << cur_q)))) // [R21]
        else $error("block end not flagged");
    abort_a: assert property (setf_w && sc == `IOBD_SC_CH1 |=> cflg_q[0] && !req[0]) // [R19]
        else $error("abort did not stop channel 1");
endmodule : iobd_top
`default_nettype wire

// ===== hw/iobd_map.svh
`ifndef IOBD_MAP_SVH
`define IOBD_MAP_SVH
// Function
// (R1) Clear-control clears the channel control bit, back to ready, lower priority unblocked.
// (R2) After reset every channel has control clear and flag set.
// (R3) Output-accumulator copies the accumulator word into the channel data buffer.
// (R4) Set-control with clear-flag option sets control and clears flag together.
// (R5) Control becoming set presents buffered data with a start pulse to the device.
// (R6) Device answers each start with one character cycle, then raises done.
// (R7) Done sets flag; interrupt to select code only if system on, priority, control.
// (R8) Flag state is readable by a skip-if-flag-set test.
// (R9) Load-input returns the channel's received device word.
// (R10) On output, flag sets only once the device accepted the word.
// (R11) Controller moves words by stealing cycles, never back to back.
// (R12) Two transfer channels, any card each; channel 1 wins ties.
// (R13) Memory cycles stay free for the processor between stolen cycles.
// (R14) Full words only, no byte packing or unpacking.
// (R15) Each transfer channel holds a 16-bit word count.
// (R16) Block end interrupts to location 6 or 7 when interrupts enabled.
// (R17) Block end also shows as testable flag at select code 6 or 7.
// (R18) Load-input at select code 2 or 3 returns that channel's word count.
// (R19) Set-flag at select code 6 or 7 aborts that channel's block.
// (R20) Assigned card flag set triggers a word move regardless of priority.
// (R21) After the last word, clear the card control, then raise completion; code clears it (bit 13 set only) on the same edge that raises completion.
// (R22) Software programs the channel, then starts the card itself.
// (R23) Assign word bit 15: set-control and clear-flag after each word, not last input.
// (R24) Assign word bit 13: clear-control to the card at block end.
// (R25) Address word holds start address; bit 15 one means into memory.
// (R26) Length word is the two's complement of 1 to 32768 words.
// (R27) Each word advances address and negative count; block ends at zero.
`define IOBD_OP_LSB 8
`define IOBD_SC_LSB 2
`define IOBD_OP_SETC 3'h0
`define IOBD_OP_SETCF 3'h1
`define IOBD_OP_CLRC 3'h2
`define IOBD_OP_SETF 3'h3
`define IOBD_OP_CLRF 3'h4
`define IOBD_OP_FTEST 3'h5
`define IOBD_OP_OUT 3'h6
`define IOBD_OP_IN 3'h7
`define IOBD_SC_INTSYS 6'h00
`define IOBD_SC_CNT1 6'h02
`define IOBD_SC_CH1 6'h06
`define IOBD_SC_CARD0 6'h08
`define IOBD_AW_SETC 15
`define IOBD_AW_CLRC 13
`define IOBD_MA_DIR 15
`define IOBD_RST_CTL 1'h0
`define IOBD_RST_FLG 1'h1
`endif

// ===== hw/iobd_pkg.sv
`default_nettype none
package iobd_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_XFER = 4'h2,
        ST_POST = 4'h4,
        ST_GAP = 4'h8
    } iobd_st_t;
    typedef struct packed {
        logic setc_opt;
        logic clrc_opt;
        logic [5:0] sc;
    } iobd_asgn_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [14:0] adr;
        logic [15:0] wdat;
    } iobd_mreq_t;
endpackage : iobd_pkg
`default_nettype wire

// ===== testbench/iobd_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module iobd_dev_model #(
    parameter int NCARD = 4
) (
    input wire logic clk_i,
    input wire logic [7:0] delay_i,
    input wire logic [NCARD-1:0] start_i,
    input wire logic [NCARD-1:0][15:0] dout_i,
    output wire logic [NCARD-1:0] done_o,
    output wire logic [NCARD-1:0][15:0] din_o,
    output wire logic [NCARD-1:0][15:0] acc_o,
    output wire logic [NCARD-1:0][7:0] starts_o
);
    ////////////////////////////////////////////////////////////////
    for (genvar g = 0; g < NCARD; g++)
    begin : card
        logic dn;
        logic [15:0] di;
        logic [15:0] ac;
        logic [7:0] ns;
        assign done_o[g] = dn;
        assign din_o[g] = di;
        assign acc_o[g] = ac;
        assign starts_o[g] = ns;
        // A start seen while busy is lost, as on a real one-shot device
        initial
        begin
            dn = 1'b0;
            di = 16'hFFFF;
            ac = 16'h0000;
            ns = 8'h00;
            forever
            begin
                @(posedge clk_i);
                if (start_i[g] === 1'b1)
                begin
                    ac <= dout_i[g];
                    ns <= ns + 8'h01;
                    repeat (delay_i) @(posedge clk_i);
                    di <= {4'hC, 4'(g), ns - 8'h01};
                    @(posedge clk_i);
                    dn <= 1'b1;
                    repeat (3) @(posedge clk_i);
                    dn <= 1'b0;
                    repeat (2) @(posedge clk_i);
                    // Data no longer held, so show a changed value
                    di <= ~di;
                end
            end
        end
    end
endmodule : iobd_dev_model
`default_nettype wire

// ===== testbench/iobd_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module iobd_top_tb;
    import iobd_pkg::*;
    localparam logic [2:0] OP_SETC = 3'h0;
    localparam logic [2:0] OP_SETCF = 3'h1;
    localparam logic [2:0] OP_CLRC = 3'h2;
    localparam logic [2:0] OP_SETF = 3'h3;
    localparam logic [2:0] OP_CLRF = 3'h4;
    localparam logic [2:0] OP_TEST = 3'h5;
    localparam logic [2:0] OP_OUT = 3'h6;
    localparam logic [2:0] OP_IN = 3'h7;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [31:0] adr_i = 32'h0;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'hF;
    logic prio_i = 1'b1;
    logic mem_ack_i = 1'b0;
    logic [15:0] mem_rdat_i = 16'h0;
    logic [7:0] delay = 8'h02;
    logic [31:0] dat_o;
    logic ack_o;
    logic irq_o;
    logic [5:0] irq_loc_o;
    logic [3:0] start_o;
    logic [3:0][15:0] dout_o;
    logic [3:0] done_i;
    logic [3:0][15:0] din_i;
    logic [3:0][15:0] acc;
    logic [3:0][7:0] starts;
    iobd_mreq_t mem_o;
    logic [15:0] mem [0:63];
    int error_cnt = 0;
    int cmp_count = 0;
    always #25 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////
    iobd_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
        .prio_i(prio_i), .irq_o(irq_o), .irq_loc_o(irq_loc_o), .start_o(start_o),
        .dout_o(dout_o), .done_i(done_i), .din_i(din_i), .mem_o(mem_o),
        .mem_ack_i(mem_ack_i), .mem_rdat_i(mem_rdat_i));
    iobd_dev_model #(.NCARD(4)) dev (.clk_i(clk_i), .delay_i(delay), .start_i(start_o),
        .dout_i(dout_o), .done_o(done_i), .din_o(din_i), .acc_o(acc), .starts_o(starts));
    // Memory answers one cycle after a request, never twice for one
    always @(posedge clk_i)
    begin
        mem_ack_i <= 1'b0;
        if (mem_o.req === 1'b1 && !mem_ack_i)
        begin
            mem_ack_i <= 1'b1;
            mem_rdat_i <= mem[mem_o.adr[5:0]];
            if (mem_o.we)
                mem[mem_o.adr[5:0]] <= mem_o.wdat;
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic wb(input logic [2:0] op, input logic [5:0] sc, input logic w,
        input logic [15:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {21'h0, op, sc, 2'h0};
        dat_i <= {16'h0, wd};
        n = 0;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        // A missing answer counts as a mismatch
        if (ack_o !== 1'b1)
            chk_bit(1'b1, ack_o);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task automatic cmd(input logic [2:0] op, input logic [5:0] sc, input logic [15:0] wd);
        logic [31:0] rd;
        wb(op, sc, 1'b1, wd, rd);
    endtask : cmd
    task automatic chk_word(input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk_word
    task automatic chk_rd(input logic [2:0] op, input logic [5:0] sc, input logic [15:0] exp);
        logic [31:0] rd;
        wb(op, sc, 1'b0, 16'h0, rd);
        chk_word(exp, rd[15:0]);
    endtask : chk_rd
    task automatic chk_bit(input logic exp, input logic got);
        chk_word({15'h0, exp}, {15'h0, got});
    endtask : chk_bit
    // Polls the flag a bounded number of times
    task automatic wait_flag(input logic [5:0] sc);
        logic [31:0] rd;
        int n;
        rd = 32'h0;
        for (n = 0; n < 60 && rd[0] !== 1'b1; n++)
            wb(OP_TEST, sc, 1'b0, 16'h0, rd);
    endtask : wait_flag
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 16'h0000;
        mem[32] = 16'h5A01;
        mem[33] = 16'h5A02;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_rd(OP_TEST, 6'h08, 16'h0001);
        chk_rd(OP_TEST, 6'h06, 16'h0001);
        cmd(OP_OUT, 6'h08, 16'h1234);
        cmd(OP_SETCF, 6'h08, 16'h0);
        chk_rd(OP_TEST, 6'h08, 16'h0000);
        wait_flag(6'h08);
        chk_rd(OP_TEST, 6'h08, 16'h0001);
        chk_word(16'h1234, acc[0]);
        // Card 8 still has control and flag set and would win the interrupt
        cmd(OP_CLRC, 6'h08, 16'h0);
        cmd(OP_SETF, 6'h00, 16'h0);
        cmd(OP_SETCF, 6'h0A, 16'h0);
        wait_flag(6'h0A);
        repeat (2) @(posedge clk_i);
        chk_bit(1'b1, irq_o);
        chk_word(16'h000A, {10'h0, irq_loc_o});
        cmd(OP_CLRC, 6'h0A, 16'h0);
        repeat (2) @(posedge clk_i);
        chk_bit(1'b0, irq_o);
        chk_rd(OP_TEST, 6'h0A, 16'h0001);
        prio_i <= 1'b0;
        cmd(OP_SETCF, 6'h0A, 16'h0);
        wait_flag(6'h0A);
        repeat (2) @(posedge clk_i);
        chk_bit(1'b0, irq_o);
        cmd(OP_CLRC, 6'h0A, 16'h0);
        prio_i <= 1'b1;
        cmd(OP_SETCF, 6'h09, 16'h0);
        wait_flag(6'h09);
        chk_rd(OP_IN, 6'h09, 16'hC100);
        cmd(OP_CLRC, 6'h09, 16'h0);
        // Both channels run at once: input on card 11, output on card 8
        cmd(OP_OUT, 6'h06, 16'hA00B);
        cmd(OP_CLRC, 6'h02, 16'h0);
        cmd(OP_OUT, 6'h02, 16'h8010);
        cmd(OP_SETC, 6'h02, 16'h0);
        cmd(OP_OUT, 6'h02, 16'hFFFD);
        cmd(OP_OUT, 6'h07, 16'h8008);
        cmd(OP_CLRC, 6'h03, 16'h0);
        cmd(OP_OUT, 6'h03, 16'h0020);
        cmd(OP_SETC, 6'h03, 16'h0);
        cmd(OP_OUT, 6'h03, 16'hFFFE);
        cmd(OP_OUT, 6'h08, 16'h0BAD);
        cmd(OP_SETCF, 6'h0B, 16'h0);
        cmd(OP_SETCF, 6'h08, 16'h0);
        cmd(OP_SETCF, 6'h06, 16'h0);
        cmd(OP_SETCF, 6'h07, 16'h0);
        wait_flag(6'h06);
        chk_rd(OP_TEST, 6'h06, 16'h0001);
        wait_flag(6'h07);
        chk_rd(OP_TEST, 6'h07, 16'h0001);
        for (int i = 0; i < 3; i++)
            chk_word({8'hC3, 8'(i)}, mem[16 + i]);
        chk_word(16'h0003, {8'h0, starts[3]});
        chk_rd(OP_IN, 6'h02, 16'h0000);
        chk_rd(OP_IN, 6'h03, 16'h0000);
        repeat (2) @(posedge clk_i);
        chk_bit(1'b1, irq_o);
        chk_word(16'h0006, {10'h0, irq_loc_o});
        repeat (30) @(posedge clk_i);
        chk_word(16'h5A02, acc[0]);
        chk_word(16'h0004, {8'h0, starts[0]});
        cmd(OP_CLRC, 6'h06, 16'h0);
        cmd(OP_CLRC, 6'h07, 16'h0);
        cmd(OP_CLRF, 6'h00, 16'h0);
        // Abort before the slow device ever answers
        delay <= 8'd40;
        cmd(OP_OUT, 6'h06, 16'h0009);
        cmd(OP_CLRC, 6'h02, 16'h0);
        cmd(OP_OUT, 6'h02, 16'h8030);
        cmd(OP_SETC, 6'h02, 16'h0);
        cmd(OP_OUT, 6'h02, 16'hFFFB);
        cmd(OP_SETCF, 6'h09, 16'h0);
        cmd(OP_SETCF, 6'h06, 16'h0);
        cmd(OP_SETF, 6'h06, 16'h0);
        repeat (120) @(posedge clk_i);
        chk_rd(OP_IN, 6'h02, 16'hFFFB);
        chk_rd(OP_TEST, 6'h06, 16'h0001);
        chk_word(16'h0000, mem[48]);
        tally_and_finish();
    end
endmodule : iobd_top_tb
`default_nettype wire
